// file: cid_data_if.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "cid_map.svh"

// Overview of operation
// - Line data shown as live serial bit and as assembled bytes.
// - Serial bit follows demodulator only while carrier detect is low.
// - Seizure pattern and mark period pass through with the message.
// - Byte-ready flag sets whenever a new byte is loaded.
// - Byte interrupt when flag, its enable set and processor mask clear.
// - Reading the byte data register clears the byte-ready flag.
// - Carrier force enable makes carrier detect follow the force bit.
// - Ring force enable makes ring detect follow the force bit.
// - Carrier interrupt enable covers real and forced carrier.
// - Ring interrupt enable covers real and forced ring.
// - Carrier flag sets on detection when enabled; requests interrupt.
// - Ring flag sets on detection when enabled; requests interrupt.
// - Carrier and ring flags share one interrupt request.
// - Flags clear only by writing zero; writing one does nothing.
// - Carrier detect reads low while a valid carrier is present.
// - Ring detect reads low while a valid ring is present.
// - Detection works only while its power-up bit is set.
// - Byte receiver runs only while its enable bit is one.
// - Source select picks processed data at zero, raw at one.
// - Carrier detect returns high only after the dropout interval.
// - Carrier declared valid only after the qualification time.
module cid_data_if
  import cid_pkg::*;
#(
  parameter int QUAL_CYC = `CID_QUAL_CYC,
  parameter int DROP_CYC = `CID_DROP_CYC,
  parameter int BIT_CYC  = `CID_BIT_CYC
)
(
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // APB slave.
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [`CID_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic [31:0]                prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Demodulator, detector and processor mask inputs.
  input  wire logic                  demod_raw_i,
  input  wire logic                  demod_cooked_i,
  input  wire logic                  carrier_sense_i,
  input  wire logic                  ring_valid_i,
  input  wire logic                  cpu_irq_mask_i,
  // Status and interrupt outputs.
  output logic                       line_irq_o,
  output logic                       byte_irq_o,
  output logic                       carrier_power_up_o,
  output logic                       ring_power_up_o,
  output logic                       carrier_present_n_o,
  output logic                       ring_present_n_o,
  output logic                       serial_line_bit_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks.

  // Counters are fixed width, so longer counts cannot be served.
  if (QUAL_CYC < 1 || DROP_CYC < 1 || BIT_CYC < 4 ||
      QUAL_CYC >= (1 << `CID_CNT_W) || DROP_CYC >= (1 << `CID_CNT_W) ||
      BIT_CYC >= (1 << `CID_CNT_W))
  begin : g_bad_param
    $error("cid_data_if: timing parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Matches a word-aligned byte address against a register index.
  function automatic logic hits(input logic [`CID_ADDR_W-1:0] addr,
                                input logic [7:0] idx);
    logic [9:0] byte_addr;
    byte_addr = {idx, 2'b00};
    hits = (byte_addr[`CID_ADDR_W-1:0] == addr) &&
           (byte_addr[9:`CID_ADDR_W] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and derived signals.

  cid_state_s s_r;
  cid_state_s s_nxt;

  logic carrier_n;
  logic ring_n;
  logic rx_src;
  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic carrier_evt;
  logic ring_evt;
  logic byte_load;

  // Detect lines are active low; force enable replaces the module output.
  assign carrier_n = s_r.carrier_force_enable ? s_r.carrier_force_bit :
                     ~(s_r.carrier_valid & s_r.carrier_power_up);
  assign ring_n    = s_r.ring_force_enable ? s_r.ring_force_bit :
                     ~(ring_valid_i & s_r.ring_power_up);
  // Source feeding the byte receiver.
  assign rx_src = s_r.raw_source_select ? demod_raw_i
                                        : demod_cooked_i;
  // Zero-wait slave: every access phase completes in one cycle.
  assign setup  = psel_i & ~penable_i;
  assign acc_wr = psel_i & penable_i & pwrite_i;
  assign acc_rd = psel_i & penable_i & ~pwrite_i;
  // A detection event is the falling edge of the active-low detect line,
  // whether caused by a real signal or by the force bit.
  assign carrier_evt = s_r.carrier_n_prev & ~carrier_n;
  assign ring_evt    = s_r.ring_n_prev & ~ring_n;
  assign byte_load   = (s_r.rx_state == CID_RX_STOP) &&
                       (s_r.rx_cnt == '0) && rx_src;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // All registers, detectors and the receiver in one process.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.carrier_n_prev = carrier_n;
    s_nxt.ring_n_prev    = ring_n;
    s_nxt.serial_line_bit = carrier_n ? 1'b1 : demod_raw_i;

    // Carrier qualifier: long presence to validate, long silence to drop.
    if (!s_r.carrier_power_up)
    begin
      s_nxt.carrier_valid = 1'b0;
      s_nxt.carrier_cnt   = '0;
    end
    else if (!s_r.carrier_valid)
    begin
      if (!carrier_sense_i)
        s_nxt.carrier_cnt = '0;
      else if (s_r.carrier_cnt == cid_cnt_t'(QUAL_CYC - 1))
      begin
        s_nxt.carrier_valid = 1'b1;
        s_nxt.carrier_cnt   = '0;
      end
      else
        s_nxt.carrier_cnt = s_r.carrier_cnt + 1'b1;
    end
    else
    begin
      if (carrier_sense_i)
        s_nxt.carrier_cnt = '0;
      else if (s_r.carrier_cnt == cid_cnt_t'(DROP_CYC - 1))
      begin
        s_nxt.carrier_valid = 1'b0;
        s_nxt.carrier_cnt   = '0;
      end
      else
        s_nxt.carrier_cnt = s_r.carrier_cnt + 1'b1;
    end

    // Byte receiver; a mid-bit sample gives the most margin on timing.
    case (s_r.rx_state)
      CID_RX_IDLE:
      begin
        if (!rx_src)
        begin
          s_nxt.rx_state = CID_RX_START;
          s_nxt.rx_cnt   = cid_cnt_t'(BIT_CYC / 2);
        end
      end
      CID_RX_START:
      begin
        if (s_r.rx_cnt != '0)
          s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
        else if (!rx_src)
        begin
          s_nxt.rx_state = CID_RX_DATA;
          s_nxt.rx_cnt   = cid_cnt_t'(BIT_CYC - 1);
          s_nxt.rx_bit   = 3'h0;
        end
        else
          s_nxt.rx_state = CID_RX_IDLE;
      end
      CID_RX_DATA:
      begin
        if (s_r.rx_cnt != '0)
          s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
        else
        begin
          s_nxt.rx_shift = {rx_src, s_r.rx_shift[7:1]};
          s_nxt.rx_bit   = s_r.rx_bit + 1'b1;
          s_nxt.rx_cnt   = cid_cnt_t'(BIT_CYC - 1);
          if (s_r.rx_bit == 3'h7)
            s_nxt.rx_state = CID_RX_STOP;
        end
      end
      CID_RX_STOP:
      begin
        if (s_r.rx_cnt != '0)
          s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
        else
          s_nxt.rx_state = CID_RX_IDLE;
      end
      default:
        s_nxt.rx_state = CID_RX_IDLE;
    endcase
    // A disabled receiver holds in idle and drops any partial byte.
    if (!s_r.byte_receiver_enable)
    begin
      s_nxt.rx_state = CID_RX_IDLE;
      s_nxt.rx_cnt   = '0;
    end

    // Register writes, taken in the access phase.
    if (acc_wr && hits(paddr_i, `CID_IDX_CS1))
    begin
      s_nxt.carrier_force_bit  = pwdata_i[`CID_CS1_CFORCE];
      s_nxt.ring_force_bit     = pwdata_i[`CID_CS1_RFORCE];
      s_nxt.carrier_irq_enable = pwdata_i[`CID_CS1_CIE];
      s_nxt.ring_irq_enable    = pwdata_i[`CID_CS1_RIE];
      // Flags only accept a zero; a one leaves them as they are.
      if (!pwdata_i[`CID_CS1_CIF])
        s_nxt.carrier_irq_flag = 1'b0;
      if (!pwdata_i[`CID_CS1_RIF])
        s_nxt.ring_irq_flag = 1'b0;
    end
    if (acc_wr && hits(paddr_i, `CID_IDX_CS2))
    begin
      s_nxt.carrier_power_up = pwdata_i[`CID_CS2_CPWR];
      s_nxt.ring_power_up    = pwdata_i[`CID_CS2_RPWR];
    end
    if (acc_wr && hits(paddr_i, `CID_IDX_CS3))
    begin
      s_nxt.carrier_force_enable  = pwdata_i[`CID_CS3_CFEN];
      s_nxt.ring_force_enable     = pwdata_i[`CID_CS3_RFEN];
      s_nxt.byte_ready_irq_enable = pwdata_i[`CID_CS3_RDYIE];
      s_nxt.byte_receiver_enable  = pwdata_i[`CID_CS3_RXEN];
      s_nxt.raw_source_select     = pwdata_i[`CID_CS3_RAWSEL];
    end
    if (acc_rd && hits(paddr_i, `CID_IDX_DATA))
      s_nxt.byte_ready_flag = 1'b0;

    // Hardware sets come last so an event beats a same-cycle clear.
    if (carrier_evt && s_r.carrier_irq_enable)
      s_nxt.carrier_irq_flag = 1'b1;
    if (ring_evt && s_r.ring_irq_enable)
      s_nxt.ring_irq_flag = 1'b1;
    // An unread byte is overwritten; software must keep up.
    if (byte_load && s_r.byte_receiver_enable)
    begin
      s_nxt.cid_byte_data   = s_r.rx_shift;
      s_nxt.byte_ready_flag = 1'b1;
    end

    // Read data is captured in the setup phase for a registered answer.
    if (setup)
    begin
      s_nxt.rdata  = 8'h00;
      s_nxt.slverr = 1'b0;
      if (hits(paddr_i, `CID_IDX_CS1))
      begin
        s_nxt.rdata[`CID_CS1_CFORCE] = s_r.carrier_force_bit;
        s_nxt.rdata[`CID_CS1_RFORCE] = s_r.ring_force_bit;
        s_nxt.rdata[`CID_CS1_CIE]    = s_r.carrier_irq_enable;
        s_nxt.rdata[`CID_CS1_CIF]    = s_r.carrier_irq_flag;
        s_nxt.rdata[`CID_CS1_RIE]    = s_r.ring_irq_enable;
        s_nxt.rdata[`CID_CS1_RIF]    = s_r.ring_irq_flag;
      end
      else if (hits(paddr_i, `CID_IDX_CS2))
      begin
        s_nxt.rdata[`CID_CS2_CDET_N] = carrier_n;
        s_nxt.rdata[`CID_CS2_RDET_N] = ring_n;
        s_nxt.rdata[`CID_CS2_SERIAL] = s_r.serial_line_bit;
        s_nxt.rdata[`CID_CS2_CPWR]   = s_r.carrier_power_up;
        s_nxt.rdata[`CID_CS2_RPWR]   = s_r.ring_power_up;
      end
      else if (hits(paddr_i, `CID_IDX_CS3))
      begin
        s_nxt.rdata[`CID_CS3_CFEN]   = s_r.carrier_force_enable;
        s_nxt.rdata[`CID_CS3_RFEN]   = s_r.ring_force_enable;
        s_nxt.rdata[`CID_CS3_RDY]    = s_r.byte_ready_flag;
        s_nxt.rdata[`CID_CS3_RDYIE]  = s_r.byte_ready_irq_enable;
        s_nxt.rdata[`CID_CS3_RXEN]   = s_r.byte_receiver_enable;
        s_nxt.rdata[`CID_CS3_RAWSEL] = s_r.raw_source_select;
      end
      else if (hits(paddr_i, `CID_IDX_DATA))
        s_nxt.rdata = s_r.cid_byte_data;
      else
        s_nxt.slverr = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Force bits and detect history reset high, so no event fires at reset.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_r                   <= '0;
      s_r.carrier_force_bit <= `CID_FORCE_RST;
      s_r.ring_force_bit    <= `CID_FORCE_RST;
      s_r.carrier_n_prev    <= 1'b1;
      s_r.ring_n_prev       <= 1'b1;
      s_r.serial_line_bit   <= 1'b1;
      s_r.rx_state          <= CID_RX_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Carrier and ring share one request line.
  assign line_irq_o = s_r.carrier_irq_flag | s_r.ring_irq_flag;
  assign byte_irq_o = s_r.byte_ready_flag & s_r.byte_ready_irq_enable &
                      ~cpu_irq_mask_i;
  assign carrier_power_up_o  = s_r.carrier_power_up;
  assign ring_power_up_o     = s_r.ring_power_up;
  assign carrier_present_n_o = carrier_n;
  assign ring_present_n_o    = ring_n;
  assign serial_line_bit_o   = s_r.serial_line_bit;
  assign prdata_o  = {24'h000000, s_r.rdata};
  assign pready_o  = 1'b1;
  assign pslverr_o = s_r.slverr & psel_i & penable_i;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_serial_idle_high: assert property (
    carrier_n |=> s_r.serial_line_bit)
    else $error("serial bit not high without carrier");

  chk_byte_sets_ready: assert property (
    (byte_load && s_r.byte_receiver_enable) |=>
      (s_r.byte_ready_flag && s_r.cid_byte_data == $past(s_r.rx_shift)))
    else $error("loaded byte without ready flag");

  chk_byte_irq_gate: assert property (
    (s_r.byte_ready_flag && s_r.byte_ready_irq_enable && !cpu_irq_mask_i)
      |-> byte_irq_o)
    else $error("byte interrupt missing");

  chk_read_clears_ready: assert property (
    (acc_rd && hits(paddr_i, `CID_IDX_DATA) && !byte_load)
      |=> !s_r.byte_ready_flag)
    else $error("data read did not clear ready flag");

  chk_carrier_force: assert property (
    s_r.carrier_force_enable |-> (carrier_n == s_r.carrier_force_bit))
    else $error("carrier detect ignores force bit");

  chk_ring_force: assert property (
    s_r.ring_force_enable |-> (ring_n == s_r.ring_force_bit))
    else $error("ring detect ignores force bit");

  chk_carrier_flag_set: assert property (
    ($fell(carrier_n) && s_r.carrier_irq_enable) |=>
      (s_r.carrier_irq_flag && line_irq_o))
    else $error("carrier flag not set on detection");

  chk_ring_flag_set: assert property (
    ($fell(ring_n) && s_r.ring_irq_enable) |=>
      (s_r.ring_irq_flag && line_irq_o))
    else $error("ring flag not set on detection");

  chk_flag_write_one: assert property (
    (acc_wr && hits(paddr_i, `CID_IDX_CS1) && pwdata_i[`CID_CS1_CIF] &&
     !s_r.carrier_irq_flag && !carrier_evt) |=> !s_r.carrier_irq_flag)
    else $error("writing one changed carrier flag");

  chk_power_off_idle: assert property (
    (!s_r.carrier_power_up && !s_r.carrier_force_enable) [*2] |-> carrier_n)
    else $error("carrier detected while powered down");

  chk_rx_disabled: assert property (
    !s_r.byte_receiver_enable |=> (s_r.rx_state == CID_RX_IDLE))
    else $error("receiver active while disabled");

endmodule

// file: cid_map.svh
`ifndef CID_MAP_SVH
`define CID_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define CID_IDX_CS1       8'h0a
`define CID_IDX_CS2       8'h0b
`define CID_IDX_CS3       8'h0c
`define CID_IDX_DATA      8'h0e
`define CID_ADDR_W        8

// Control/status one field positions.
`define CID_CS1_CFORCE    0
`define CID_CS1_RFORCE    1
`define CID_CS1_CIE       4
`define CID_CS1_CIF       5
`define CID_CS1_RIE       6
`define CID_CS1_RIF       7

// Control/status two field positions.
`define CID_CS2_CDET_N    0
`define CID_CS2_RDET_N    1
`define CID_CS2_SERIAL    2
`define CID_CS2_CPWR      5
`define CID_CS2_RPWR      6

// Control/status three field positions.
`define CID_CS3_CFEN      0
`define CID_CS3_RFEN      1
`define CID_CS3_RDY       2
`define CID_CS3_RDYIE     3
`define CID_CS3_RXEN      4
`define CID_CS3_RAWSEL    7

// Reset values of the force bits.
`define CID_FORCE_RST     1'b1

// Timing: clock, carrier qualification, carrier dropout, line rate.
`define CID_CLK_NS        50
`define CID_CLK_HZ        20000000
`define CID_QUAL_MS       25
`define CID_DROP_MS       8
`define CID_BAUD          1200
`define CID_QUAL_CYC ((`CID_QUAL_MS * 1000000 + `CID_CLK_NS - 1) / `CID_CLK_NS)
`define CID_DROP_CYC ((`CID_DROP_MS * 1000000 + `CID_CLK_NS - 1) / `CID_CLK_NS)
`define CID_BIT_CYC       (`CID_CLK_HZ / `CID_BAUD)
`define CID_CNT_W         24

`endif

// file: cid_pkg.sv
`include "cid_map.svh"

package cid_pkg;

  // Byte receiver states, Gray coded along idle-start-data-stop.
  typedef enum logic [1:0]
  {
    CID_RX_IDLE  = 2'b00,
    CID_RX_START = 2'b01,
    CID_RX_DATA  = 2'b11,
    CID_RX_STOP  = 2'b10
  } cid_rx_e;

  typedef logic [`CID_CNT_W-1:0] cid_cnt_t;

  // Complete state of the caller-ID data interface.
  typedef struct packed {
    logic     ring_irq_flag;
    logic     ring_irq_enable;
    logic     carrier_irq_flag;
    logic     carrier_irq_enable;
    logic     ring_force_bit;
    logic     carrier_force_bit;
    logic     ring_power_up;
    logic     carrier_power_up;
    logic     raw_source_select;
    logic     byte_receiver_enable;
    logic     byte_ready_irq_enable;
    logic     byte_ready_flag;
    logic     ring_force_enable;
    logic     carrier_force_enable;
    logic     carrier_valid;
    cid_cnt_t carrier_cnt;
    logic     carrier_n_prev;
    logic     ring_n_prev;
    logic     serial_line_bit;
    cid_rx_e  rx_state;
    cid_cnt_t rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] cid_byte_data;
    logic [7:0] rdata;
    logic       slverr;
  } cid_state_s;

endpackage

// file: cid_line_model.sv
`timescale 1ns/1ps

// Demodulator stand-in: one framed byte per go pulse; cooked line idles at mark, raw line at idle_raw_i.
module cid_line_model #(
  parameter int BIT_CYC = 8
)
(
  // Clock and commands.
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       use_raw_i,
  input  wire logic       idle_raw_i,
  // Line outputs.
  output logic            raw_o,
  output logic            cooked_o,
  output logic            busy_o
);
  logic       line_r;
  logic [9:0] frame;

  initial
  begin
    busy_o = 1'b0;
    line_r = 1'b1;
  end

  // Low start, eight bits LSB first, high stop; then back to mark.
  always @(posedge clk_i)
  begin
    if (go_i && !busy_o)
    begin
      busy_o <= 1'b1;
      frame = {1'b1, byte_i, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        line_r <= frame[i];
        repeat (BIT_CYC) @(posedge clk_i);
      end
      busy_o <= 1'b0;
    end
  end

  // Only the chosen line carries the frame, so a wrong select is visible.
  assign raw_o    = (busy_o && use_raw_i) ? line_r : idle_raw_i;
  assign cooked_o = (busy_o && !use_raw_i) ? line_r : 1'b1;
endmodule

// file: cid_data_if_test.sv
`timescale 1ns/1ps
`include "cid_map.svh"

module cid_data_if_test;
  localparam int         QC = 20;
  localparam int         DC = 10;
  localparam int         BC = 8;
  localparam logic [7:0] A1 = 8'(`CID_IDX_CS1 * 4);
  localparam logic [7:0] A2 = 8'(`CID_IDX_CS2 * 4);
  localparam logic [7:0] A3 = 8'(`CID_IDX_CS3 * 4);
  localparam logic [7:0] AD = 8'(`CID_IDX_DATA * 4);
  // Receiver cases: config, raw line used, byte expected.
  localparam logic [7:0] CFG [4] = '{8'h18, 8'h98, 8'h98, 8'h08};
  localparam logic [3:0] USE_RAW = 4'b0010;
  localparam logic [3:0] EXP     = 4'b0011;

  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        carrier_sense_i = 1'b0;
  logic        ring_valid_i = 1'b0;
  logic        cpu_irq_mask_i = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  tx_byte = 8'h00;
  logic        use_raw = 1'b0;
  logic        idle_raw = 1'b1;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, line_irq_o, byte_irq_o;
  logic        carrier_power_up_o, ring_power_up_o, serial_line_bit_o;
  logic        carrier_present_n_o, ring_present_n_o;
  logic        raw, cooked, busy, err;
  logic [7:0]  rv, b;
  int          failures = 0;
  int          checked = 0;

  // Free-running system clock.
  always #25 clk_i = ~clk_i;

  cid_data_if #(
    .QUAL_CYC (QC),
    .DROP_CYC (DC),
    .BIT_CYC  (BC)
  )
  dut
  (
    .clk_i               (clk_i),
    .rstn_i              (rstn_i),
    .psel_i              (psel_i),
    .penable_i           (penable_i),
    .pwrite_i            (pwrite_i),
    .paddr_i             (paddr_i),
    .pwdata_i            (pwdata_i),
    .prdata_o            (prdata_o),
    .pready_o            (pready_o),
    .pslverr_o           (pslverr_o),
    .demod_raw_i         (raw),
    .demod_cooked_i      (cooked),
    .carrier_sense_i     (carrier_sense_i),
    .ring_valid_i        (ring_valid_i),
    .cpu_irq_mask_i      (cpu_irq_mask_i),
    .line_irq_o          (line_irq_o),
    .byte_irq_o          (byte_irq_o),
    .carrier_power_up_o  (carrier_power_up_o),
    .ring_power_up_o     (ring_power_up_o),
    .carrier_present_n_o (carrier_present_n_o),
    .ring_present_n_o    (ring_present_n_o),
    .serial_line_bit_o   (serial_line_bit_o)
  );

  cid_line_model #(.BIT_CYC (BC)) line_model
  (
    .clk_i      (clk_i),
    .go_i       (go),
    .byte_i     (tx_byte),
    .use_raw_i  (use_raw),
    .idle_raw_i (idle_raw),
    .raw_o      (raw),
    .cooked_o   (cooked),
    .busy_o     (busy)
  );

  // Closing verdict, shared by the main sequence and the watchdog.
  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Register value comparison.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string m);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask

  // Pin level comparison.
  task automatic chk1(input logic got, input logic exp, input string m);
    chk8({7'h0, got}, {7'h0, exp}, m);
  endtask

  // APB transfer; waits on pready, so a stuck slave only trips the watchdog.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    rv = prdata_o[7:0];
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
    apb(1'b0, a, 8'h00);
    chk8(rv, e, m);
  endtask

  // Bounded wait for a level, sampled off the edge, then compared.
  task automatic wait_lvl(ref logic s, input logic v, input int max,
                          input string m);
    @(negedge clk_i);
    for (int n = 0; n < max && s !== v; n++) @(negedge clk_i);
    chk1(s, v, m);
  endtask

  task automatic send(input logic [7:0] v, input logic r);
    @(posedge clk_i);
    go      <= 1'b1;
    tx_byte <= v;
    use_raw <= r;
    @(posedge clk_i) go <= 1'b0;
    wait_lvl(busy, 1'b0, 12 * BC, "frame end");
    repeat (4) @(negedge clk_i);
  endtask

  //////////////////////////////////////////////////////////////////////////////

  // Watchdog: the whole sequence needs well under 3000 cycles.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'h39c8));
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(A1, 8'h03, "cs1 reset");
    rd(A2, 8'h07, "cs2 reset");
    rd(A3, 8'h00, "cs3 reset");
    rd(8'h3c, 8'h00, "unmapped read");
    chk1(err, 1'b1, "unmapped error");
    apb(1'b1, A1, 8'h53);
    @(posedge clk_i) carrier_sense_i <= 1'b1;
    ring_valid_i <= 1'b1;
    repeat (30) @(negedge clk_i);
    chk1(carrier_present_n_o, 1'b1, "carrier unpowered");
    chk1(ring_present_n_o, 1'b1, "ring unpowered");
    apb(1'b1, A2, 8'h60);
    wait_lvl(ring_present_n_o, 1'b0, 4, "ring detect");
    repeat (QC - 6) @(negedge clk_i);
    chk1(carrier_present_n_o, 1'b1, "carrier early");
    wait_lvl(carrier_present_n_o, 1'b0, 10, "carrier");
    repeat (3) @(negedge clk_i);
    chk1(carrier_power_up_o & ring_power_up_o, 1'b1, "power");
    rd(A1, 8'hf3, "both flags");
    chk1(line_irq_o, 1'b1, "line irq");
    apb(1'b1, A1, 8'hf3);
    rd(A1, 8'hf3, "flag write one");
    apb(1'b1, A1, 8'h73);
    rd(A1, 8'h73, "ring flag clear");
    chk1(line_irq_o, 1'b1, "carrier alone");
    apb(1'b1, A1, 8'h53);
    rd(A1, 8'h53, "carrier flag clear");
    chk1(line_irq_o, 1'b0, "flags clear");
    // Live serial bit while a carrier is detected.
    @(posedge clk_i) idle_raw <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk1(serial_line_bit_o, 1'b0, "serial follows");
    rd(A2, 8'h60, "cs2 live");
    @(posedge clk_i) idle_raw <= 1'b1;
    @(posedge clk_i) carrier_sense_i <= 1'b0;
    ring_valid_i <= 1'b0;
    repeat (DC - 2) @(negedge clk_i);
    chk1(carrier_present_n_o, 1'b0, "carrier held");
    wait_lvl(carrier_present_n_o, 1'b1, 6, "carrier drop");
    @(posedge clk_i) idle_raw <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk1(serial_line_bit_o, 1'b1, "serial idle");
    @(posedge clk_i) idle_raw <= 1'b1;
    // Forced detection ignores the modules and still raises the flags.
    apb(1'b1, A3, 8'h03);
    apb(1'b1, A1, 8'h50);
    wait_lvl(carrier_present_n_o, 1'b0, 3, "carrier forced");
    wait_lvl(ring_present_n_o, 1'b0, 3, "ring forced");
    rd(A1, 8'hf0, "forced flags");
    apb(1'b1, A1, 8'h53);
    wait_lvl(carrier_present_n_o, 1'b1, 3, "carrier unforced");
    chk1(ring_present_n_o, 1'b1, "ring unforced");
    apb(1'b1, A3, 8'h00);
    // Byte receiver over source and enable settings.
    for (int k = 0; k < 4; k++)
    begin
      b = (k == 0) ? 8'h55 : 8'($urandom);
      apb(1'b1, A3, CFG[k]);
      send(b, USE_RAW[k]);
      rd(A3, CFG[k] | {5'h0, EXP[k], 2'h0}, "ready");
      if (EXP[k])
      begin
        chk1(byte_irq_o, 1'b1, "byte irq");
        @(posedge clk_i) cpu_irq_mask_i <= 1'b1;
        @(negedge clk_i);
        chk1(byte_irq_o, 1'b0, "byte irq masked");
        @(posedge clk_i) cpu_irq_mask_i <= 1'b0;
        rd(AD, b, "byte data");
        rd(A3, CFG[k], "ready cleared");
      end
    end
    report_and_stop();
  end
endmodule
